// *** design/speed_status_clamp.sv ***
// Speed-mode status outputs, zero clamp and torque source select
`timescale 1ns/1ps
`default_nettype none
`include "speed_status_consts.svh"

// Notes on behaviour
// (RULE1) Clamp with small reference zeroes command, ignores reference
// (RULE2) Policy 0 zero, 1 lock-by-speed, 2 lock, 3 off
// (RULE3) Clamp threshold 0 to 1000 rpm, default 20
// (RULE4) Rotating when speed magnitude reaches rotation threshold
// (RULE5) Code 132 routes rotating status to output
// (RULE6) Standstill while speed magnitude below zero threshold
// (RULE7) Code 133 routes standstill status to output
// (RULE8) Match while speed error within match threshold
// (RULE9) Code 135 routes match status to output
// (RULE10) Reached while speed magnitude above approach threshold
// (RULE11) Code 136 routes reached status to output
// (RULE12) Each output has function code and polarity
// (RULE13) Torque source internal or analog, changed stopped
// (RULE14) Compare magnitudes afresh on every control tick
module speed_status_clamp
  import speed_status_pkg::*;
(
  // Clock and reset
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RST_I,
  // AHB-Lite slave
  input  wire logic                  HSEL_I,
  input  wire logic [31:0]           HADDR_I,
  input  wire logic [1:0]            HTRANS_I,
  input  wire logic                  HWRITE_I,
  input  wire logic [2:0]            HSIZE_I,
  input  wire logic [31:0]           HWDATA_I,
  input  wire logic                  HREADY_I,
  output logic [31:0]                HRDATA_O,
  output logic                       HREADYOUT_O,
  output logic                       HRESP_O,
  // Drive state and speed values
  input  wire logic                  CTRL_TICK_I,
  input  wire logic                  SPEED_MODE_I,
  input  wire logic                  RUNNING_I,
  input  wire logic                  CLAMP_REQ_I,
  input  wire speed_status_pkg::speed_t SPEED_FB_I,
  input  wire speed_status_pkg::speed_t SPEED_REF_I,
  input  wire speed_status_pkg::speed_t TORQUE_INT_I,
  input  wire speed_status_pkg::speed_t FIRST_ANALOG_I,
  // Loop commands
  output speed_status_pkg::speed_t   SPEED_CMD_O,
  output logic                       POS_LOCK_O,
  output speed_status_pkg::speed_t   TORQUE_REF_O,
  // Status and terminals
  output logic                       ROTATING_O,
  output logic                       STANDSTILL_O,
  output logic                       SPEED_MATCH_O,
  output logic                       SPEED_REACHED_O,
  output logic [`NUM_OUT-1:0]        DO_O,
  output logic                       IRQ_O
);
  import speed_status_pkg::*;

  // ========================================================
  // Registers
  param_t            policy_q;
  param_t            clamp_thr_q;
  param_t            rot_thr_q;
  param_t            zero_thr_q;
  param_t            match_thr_q;
  param_t            appr_thr_q;
  logic [7:0]        func_q [`NUM_OUT];
  logic [`NUM_OUT-1:0] pol_q;
  param_t            torque_src_q;
  logic [`ST_W-1:0]  irq_st_q;
  logic [`ST_W-1:0]  irq_mask_q;
  logic [`ST_W-1:0]  status_q;
  logic [`ST_W-1:0]  status_d;
  clamp_state_t      clamp_q;
  clamp_state_t      clamp_d;
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic [31:0]       rdata_q;
  logic [`NUM_OUT-1:0] do_q;
  speed_t            speed_cmd_q;
  speed_t            torque_q;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  // ========================================================
  // Bus slave: zero wait state, always OKAY
  logic       ahb_go;
  logic [7:0] wdat8;
  param_t     wdat;
  assign ahb_go      = HSEL_I && HREADY_I && HTRANS_I[1];
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_q;
  assign wdat        = HWDATA_I[15:0];
  assign wdat8       = HWDATA_I[7:0];

  function automatic logic wsel(input logic [7:0] ofs);
    return wr_pend_q && (wr_addr_q == ofs);
  endfunction

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= ahb_go && HWRITE_I;
      if (ahb_go) begin
        wr_addr_q <= HADDR_I[7:0];
      end
    end
  end

  // Read data captured in the address phase, unmapped reads zero
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (HADDR_I[7:0])
      `OFS_CLAMP_POLICY: rmux[15:0] = policy_q;
      `OFS_CLAMP_THR:    rmux[15:0] = clamp_thr_q;
      `OFS_ROT_THR:      rmux[15:0] = rot_thr_q;
      `OFS_ZERO_THR:     rmux[15:0] = zero_thr_q;
      `OFS_MATCH_THR:    rmux[15:0] = match_thr_q;
      `OFS_APPR_THR:     rmux[15:0] = appr_thr_q;
      `OFS_OUT_FUNC_A:   rmux[7:0]  = func_q[0];
      `OFS_OUT_FUNC_B:   rmux[7:0]  = func_q[1];
      `OFS_OUT_POLARITY: rmux[`NUM_OUT-1:0] = pol_q;
      `OFS_TORQUE_SRC:   rmux[15:0] = torque_src_q;
      `OFS_LIVE_STATUS:  rmux[`ST_W-1:0] = status_q;
      `OFS_IRQ_STATUS:   rmux[`ST_W-1:0] = irq_st_q;
      `OFS_IRQ_MASK:     rmux[`ST_W-1:0] = irq_mask_q;
      default:           rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (ahb_go && !HWRITE_I) begin
      rdata_q <= rmux;
    end
  end

  // ========================================================
  // Parameter registers; out-of-range writes are dropped
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      policy_q    <= `RST_CLAMP_POLICY;
      clamp_thr_q <= `RST_CLAMP_THR;
      rot_thr_q   <= `RST_ROT_THR;
      zero_thr_q  <= `RST_ZERO_THR;
      match_thr_q <= `RST_MATCH_THR;
      appr_thr_q  <= `RST_APPR_THR;
    end else begin
      if (wsel(`OFS_CLAMP_POLICY) && wdat <= `MAX_CLAMP_POLICY) begin
        policy_q <= wdat; // RULE2
      end
      if (wsel(`OFS_CLAMP_THR) && wdat <= `MAX_CLAMP_THR) begin
        clamp_thr_q <= wdat; // RULE3
      end
      if (wsel(`OFS_ROT_THR) && wdat <= `MAX_ROT_THR) begin
        rot_thr_q <= wdat;
      end
      if (wsel(`OFS_ZERO_THR) && wdat <= `MAX_ZERO_THR) begin
        zero_thr_q <= wdat;
      end
      if (wsel(`OFS_MATCH_THR) && wdat <= `MAX_MATCH_THR) begin
        match_thr_q <= wdat;
      end
      if (wsel(`OFS_APPR_THR) && wdat >= `MIN_APPR_THR &&
          wdat <= `MAX_APPR_THR) begin
        appr_thr_q <= wdat;
      end
    end
  end

  // Source change only while stopped, else the loop would jump
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      torque_src_q <= `RST_TORQUE_SRC;
    end else if (wsel(`OFS_TORQUE_SRC) && !RUNNING_I &&
                 wdat <= `MAX_TORQUE_SRC) begin
      torque_src_q <= wdat; // RULE13
    end
  end

  // Terminal function codes outside the legal span are dropped
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      func_q[0] <= `RST_OUT_FUNC_A;
      func_q[1] <= `RST_OUT_FUNC_B;
      pol_q     <= '0;
    end else begin
      if (wsel(`OFS_OUT_FUNC_A) && wdat8 >= `FUNC_MIN &&
          wdat8 <= `FUNC_MAX && HWDATA_I[15:8] == 8'h00) begin
        func_q[0] <= wdat8; // RULE12
      end
      if (wsel(`OFS_OUT_FUNC_B) && wdat8 >= `FUNC_MIN &&
          wdat8 <= `FUNC_MAX && HWDATA_I[15:8] == 8'h00) begin
        func_q[1] <= wdat8; // RULE12
      end
      if (wsel(`OFS_OUT_POLARITY)) begin
        pol_q <= HWDATA_I[`NUM_OUT-1:0]; // RULE12
      end
    end
  end

  // ========================================================
  // Magnitudes and comparisons
  function automatic param_t mag(input speed_t v);
    return v[15] ? param_t'(-v) : param_t'(v);
  endfunction

  param_t      abs_fb;
  param_t      abs_ref;
  logic [16:0] err;
  logic [16:0] abs_err;
  assign abs_fb  = mag(SPEED_FB_I); // RULE14
  assign abs_ref = mag(SPEED_REF_I); // RULE14
  assign err     = 17'(SPEED_FB_I) - 17'(SPEED_REF_I);
  assign abs_err = err[16] ? 17'(-err) : err;

  always_comb begin
    status_d = '0;
    status_d[`ST_ROT]   = abs_fb >= rot_thr_q; // RULE4
    status_d[`ST_ZERO]  = abs_fb < zero_thr_q; // RULE6
    status_d[`ST_MATCH] = SPEED_MODE_I &&
                          abs_err <= {1'b0, match_thr_q}; // RULE8
    status_d[`ST_REACH] = abs_fb > appr_thr_q; // RULE10
    status_d[`ST_LOCK]  = clamp_d == CL_LOCK;
  end

  // ========================================================
  // Zero clamp state
  logic clamp_req;
  assign clamp_req = CLAMP_REQ_I && SPEED_MODE_I &&
                     policy_q != `POLICY_IGNORE &&
                     abs_ref < clamp_thr_q; // RULE1

  always_comb begin
    clamp_d = CL_OFF;
    if (clamp_req) begin
      case (policy_q[1:0]) // RULE2
        2'b00: clamp_d = CL_ZERO;
        2'b01: clamp_d = (clamp_q == CL_LOCK ||
                          abs_fb < clamp_thr_q) ? CL_LOCK : CL_ZERO;
        2'b10: clamp_d = CL_LOCK;
        default: clamp_d = CL_OFF;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clamp_q <= CL_OFF;
    end else if (CTRL_TICK_I) begin
      clamp_q <= clamp_d;
    end
  end

  // Commands refresh once per control tick
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      speed_cmd_q <= '0;
      torque_q    <= '0;
    end else if (CTRL_TICK_I) begin
      speed_cmd_q <= (clamp_d != CL_OFF) ? speed_t'(0)
                                         : SPEED_REF_I; // RULE1
      torque_q    <= torque_src_q[0] ? FIRST_ANALOG_I
                                     : TORQUE_INT_I; // RULE13
    end
  end
  assign SPEED_CMD_O  = speed_cmd_q;
  assign TORQUE_REF_O = torque_q;
  assign POS_LOCK_O   = clamp_q == CL_LOCK;

  // ========================================================
  // Status flags, re-evaluated each tick without latching
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_q <= '0;
    end else if (CTRL_TICK_I) begin
      status_q <= status_d; // RULE14
    end
  end
  assign ROTATING_O      = status_q[`ST_ROT];
  assign STANDSTILL_O    = status_q[`ST_ZERO];
  assign SPEED_MATCH_O   = status_q[`ST_MATCH];
  assign SPEED_REACHED_O = status_q[`ST_REACH];

  // ========================================================
  // Output terminals: function select then polarity
  for (genvar t = 0; t < `NUM_OUT; t++) begin : g_out
    logic sel;
    always_comb begin
      case (func_q[t])
        `FUNC_ROTATING:    sel = status_d[`ST_ROT]; // RULE5
        `FUNC_STANDSTILL:  sel = status_d[`ST_ZERO]; // RULE7
        `FUNC_SPEED_MATCH: sel = status_d[`ST_MATCH]; // RULE9
        `FUNC_REACHED:     sel = status_d[`ST_REACH]; // RULE11
        default:           sel = 1'b0;
      endcase
    end
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        do_q[t] <= 1'b0;
      end else if (CTRL_TICK_I) begin
        do_q[t] <= sel ^ pol_q[t]; // RULE12
      end
    end
  end
  assign DO_O = do_q;

  // ========================================================
  // Interrupts: rising status edges, set beats write-one-clear
  logic [`ST_W-1:0] rise;
  logic [`ST_W-1:0] clr;
  assign rise = CTRL_TICK_I ? (status_d & ~status_q) : '0;
  assign clr  = wsel(`OFS_IRQ_STATUS) ? HWDATA_I[`ST_W-1:0] : '0;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~clr) | rise;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_mask_q <= '0;
    end else if (wsel(`OFS_IRQ_MASK)) begin
      irq_mask_q <= HWDATA_I[`ST_W-1:0];
    end
  end
  assign IRQ_O = |(irq_st_q & irq_mask_q);

  // ========================================================
  // Checks
  sequence s_tick_clamped;
    CTRL_TICK_I && clamp_d != CL_OFF;
  endsequence
  sequence s_cmd_zero;
    SPEED_CMD_O == 16'sh0000;
  endsequence

  a_clamp_zeroes_cmd: assert property ( // RULE1
    s_tick_clamped |=> s_cmd_zero)
    else $error("Clamped tick did not zero the speed command");
  a_policy_ignore: assert property ( // RULE2
    CTRL_TICK_I && policy_q == `POLICY_IGNORE |=> !POS_LOCK_O
      && SPEED_CMD_O == $past(SPEED_REF_I))
    else $error("Ignore policy still clamped");
  a_policy_two_lock: assert property ( // RULE2
    CTRL_TICK_I && clamp_req && policy_q == `POLICY_LOCK |=> POS_LOCK_O)
    else $error("Policy two did not lock position");
  a_clamp_thr_range: assert property ( // RULE3
    clamp_thr_q <= `MAX_CLAMP_THR)
    else $error("Clamp threshold out of range");
  a_rotating_level: assert property ( // RULE4
    CTRL_TICK_I |=> ROTATING_O == ($past(abs_fb) >= $past(rot_thr_q)))
    else $error("Rotating status wrong");
  a_route_rotating: assert property ( // RULE5
    CTRL_TICK_I && func_q[0] == `FUNC_ROTATING && !pol_q[0]
      |=> DO_O[0] == ROTATING_O)
    else $error("Rotating status not on terminal");
  a_standstill_lvl: assert property ( // RULE6
    CTRL_TICK_I |=> STANDSTILL_O == ($past(abs_fb) < $past(zero_thr_q)))
    else $error("Standstill status wrong");
  a_route_standstill: assert property ( // RULE7
    CTRL_TICK_I && func_q[1] == `FUNC_STANDSTILL && !pol_q[1]
      |=> DO_O[1] == STANDSTILL_O)
    else $error("Standstill status not on terminal");
  a_match_level: assert property ( // RULE8
    CTRL_TICK_I && SPEED_MODE_I && abs_err > {1'b0, match_thr_q}
      |=> !SPEED_MATCH_O)
    else $error("Match status set beyond threshold");
  a_route_match: assert property ( // RULE9
    CTRL_TICK_I && func_q[0] == `FUNC_SPEED_MATCH && !pol_q[0]
      |=> DO_O[0] == SPEED_MATCH_O)
    else $error("Match status not on terminal");
  a_reached_level: assert property ( // RULE10
    CTRL_TICK_I |=> SPEED_REACHED_O == ($past(abs_fb) > $past(appr_thr_q)))
    else $error("Reached status wrong");
  a_route_reached: assert property ( // RULE11
    CTRL_TICK_I && func_q[1] == `FUNC_REACHED && pol_q[1]
      |=> DO_O[1] == !SPEED_REACHED_O)
    else $error("Inverted reached status not on terminal");
  a_torque_src_held: assert property ( // RULE13
    RUNNING_I |=> $stable(torque_src_q))
    else $error("Torque source changed while running");
  a_status_no_latch: assert property ( // RULE14
    CTRL_TICK_I && !status_d[`ST_ROT] |=> !ROTATING_O)
    else $error("Rotating status latched");
  a_irq_set_wins: assert property (
    rise[`ST_ROT] |=> irq_st_q[`ST_ROT])
    else $error("Status event lost");

endmodule
`default_nettype wire

// *** design/speed_status_consts.svh ***
// Constants for the speed status and zero clamp block
`ifndef SPEED_STATUS_CONSTS_SVH
`define SPEED_STATUS_CONSTS_SVH

// ==========================================================
// Register byte offsets (low address byte)
`define OFS_CLAMP_POLICY   8'h00
`define OFS_CLAMP_THR      8'h04
`define OFS_ROT_THR        8'h08
`define OFS_ZERO_THR       8'h0C
`define OFS_MATCH_THR      8'h10
`define OFS_APPR_THR       8'h14
`define OFS_OUT_FUNC_A     8'h18
`define OFS_OUT_FUNC_B     8'h1C
`define OFS_OUT_POLARITY   8'h20
`define OFS_TORQUE_SRC     8'h24
`define OFS_LIVE_STATUS    8'h28
`define OFS_IRQ_STATUS     8'h2C
`define OFS_IRQ_MASK       8'h30

// ==========================================================
// Reset values
`define RST_CLAMP_POLICY   16'h0000
`define RST_CLAMP_THR      16'h0014
`define RST_ROT_THR        16'h0014
`define RST_ZERO_THR       16'h000A
`define RST_MATCH_THR      16'h000A
`define RST_APPR_THR       16'h0064
`define RST_OUT_FUNC_A     8'h83
`define RST_OUT_FUNC_B     8'h84
`define RST_TORQUE_SRC     16'h0000

// ==========================================================
// Legal ranges of writable fields
`define MAX_CLAMP_POLICY   16'h0003
`define MAX_CLAMP_THR      16'h03E8
`define MAX_ROT_THR        16'h03E8
`define MAX_ZERO_THR       16'h1770
`define MAX_MATCH_THR      16'h0064
`define MIN_APPR_THR       16'h000A
`define MAX_APPR_THR       16'h1770
`define MAX_TORQUE_SRC     16'h0001
`define FUNC_MIN           8'h80
`define FUNC_MAX           8'h8E

// ==========================================================
// Output function codes and status bit positions
`define FUNC_ROTATING      8'h84
`define FUNC_STANDSTILL    8'h85
`define FUNC_SPEED_MATCH   8'h87
`define FUNC_REACHED       8'h88
`define POLICY_IGNORE      16'h0003
`define POLICY_LOCK        16'h0002
`define ST_ROT             0
`define ST_ZERO            1
`define ST_MATCH           2
`define ST_REACH           3
`define ST_LOCK            4
`define ST_W               5
`define NUM_OUT            2

`endif

// *** design/speed_status_pkg.sv ***
// Types shared by the speed status and zero clamp block
`default_nettype none
package speed_status_pkg;
  typedef logic signed [15:0] speed_t;
  typedef logic [15:0]        param_t;
  typedef enum logic [1:0] {
    CL_OFF  = 2'b00,
    CL_ZERO = 2'b01,
    CL_LOCK = 2'b10
  } clamp_state_t;
endpackage
`default_nettype wire

// *** tb/do_reader.sv ***
// Host-side model that scans the drive's output terminals
`timescale 1ns/1ps
`default_nettype none

module do_reader (
  // Clock and terminals
  input  wire logic       clk_i,
  input  wire logic [1:0] term_i,
  // Levels last seen by the host
  output logic [1:0]      level_o
);
  // ==========================================================
  // Input scan
  // One scan a cycle; the host sees terminal levels one cycle late
  always_ff @(posedge clk_i) begin
    level_o <= term_i;
  end
endmodule

`default_nettype wire

// *** tb/speed_status_clamp_bench.sv ***
// Self-checking bench for the speed status and zero clamp block
`timescale 1ns/1ps
`default_nettype none
`include "speed_status_consts.svh"

module speed_status_clamp_bench;
  import speed_status_pkg::*;
  logic        clk, rst, hsel, hwrite, tick, smode, run, clreq;
  logic [31:0] haddr, hwdata, rdata;
  logic [1:0]  htrans;
  speed_t      fb, sref, tint, ain;
  wire logic [31:0] hrdata;
  wire logic   hready, hresp, lock, rot, zero, match, reach, irq;
  wire speed_t cmd, tref;
  wire logic [1:0] term, seen;
  int          bad_count, check_count;
  logic [7:0]  ofs_tab [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  logic [31:0] rst_tab [10] = '{32'h0, 32'h14, 32'h14, 32'hA, 32'hA,
                                32'h64, 32'h83, 32'h84, 32'h0, 32'h0};
  speed_t      fb_tab [9] = '{19, 20, -20, 9, 10, -9, 100, 101, -101};
  logic [2:0]  st_tab [9] = '{3'h0, 3'h4, 3'h4, 3'h2, 3'h0, 3'h2,
                              3'h4, 3'h5, 3'h5};
  logic [7:0]  code_tab [4] = '{8'h84, 8'h85, 8'h87, 8'h88};
  logic        code_exp [4] = '{1'b1, 1'b1, 1'b1, 1'b1};
  // Each speed pair drives the selected status high
  speed_t      tf [4] = '{50, 0, 15, 200};
  speed_t      tr [4] = '{0, 50, 15, 0};
  logic [1:0]  cp [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  speed_t      cf [6] = '{30, 30, 30, 5, 30, 30};
  speed_t      cr [6] = '{10, 25, 10, 10, 10, 10};
  speed_t      cc [6] = '{0, 25, 0, 0, 0, 10};
  logic        cl [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  speed_status_clamp dut (
    .REF_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .CTRL_TICK_I(tick),
    .SPEED_MODE_I(smode), .RUNNING_I(run), .CLAMP_REQ_I(clreq),
    .SPEED_FB_I(fb), .SPEED_REF_I(sref), .TORQUE_INT_I(tint),
    .FIRST_ANALOG_I(ain), .SPEED_CMD_O(cmd), .POS_LOCK_O(lock),
    .TORQUE_REF_O(tref), .ROTATING_O(rot), .STANDSTILL_O(zero),
    .SPEED_MATCH_O(match), .SPEED_REACHED_O(reach), .DO_O(term),
    .IRQ_O(irq)
  );

  do_reader host (
    .clk_i(clk), .term_i(term), .level_o(seen)
  );

  always #5 clk = ~clk;

  // ==========================================================
  // Reporting
  task automatic results;
    $display("bad_count=%0d check_count=%0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_port(input string n, input logic [15:0] e,
                          input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // ==========================================================
  // Bus and tick drivers
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        $display("unexpected hready expected 1 seen %b", hready);
        results();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rdata = hrdata;
    #1;
  endtask

  task automatic step(input speed_t f, input speed_t r);
    @(posedge clk);
    fb <= f;
    sref <= r;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 0; rst = 1; hsel = 0; htrans = 0; hwrite = 0; haddr = 0;
    hwdata = 0; tick = 0; smode = 1; run = 0; clreq = 0; fb = 0;
    sref = 0; tint = 16'sd77; ain = -16'sd55;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      bus(0, ofs_tab[i], 0);
      chk_reg("reset value", rst_tab[i], rdata);
    end
    bus(0, 8'h40, 0);
    chk_reg("unmapped read", 32'h0, rdata);
    chk_port("response", 16'h0, 16'(hresp));
    // Magnitude compares on either side of each threshold
    for (int i = 0; i < 9; i++) begin
      step(fb_tab[i], 0);
      chk_port("rot zero reach", 16'(st_tab[i]), 16'({rot, zero, reach}));
    end
    step(60, 50);
    chk_port("match", 16'h1, 16'(match));
    step(61, 50);
    chk_port("match", 16'h0, 16'(match));
    step(-40, -50);
    chk_port("match", 16'h1, 16'(match));
    bus(1, `OFS_MATCH_THR, 32'h0);
    step(50, 50);
    chk_port("match", 16'h1, 16'(match));
    step(51, 50);
    chk_port("match", 16'h0, 16'(match));
    bus(1, `OFS_MATCH_THR, 32'hA);
    chk_port("terminal B", 16'h1, 16'(seen[1]));
    // Terminal routing under both polarities
    for (int p = 0; p < 2; p++) begin
      bus(1, `OFS_OUT_POLARITY, {30'h0, p[0], p[0]});
      for (int k = 0; k < 4; k++) begin
        bus(1, `OFS_OUT_FUNC_A, {24'h0, code_tab[k]});
        bus(1, `OFS_OUT_FUNC_B, {24'h0, code_tab[k]});
        step(tf[k], tr[k]);
        @(posedge clk);
        #1;
        chk_port("terminal A", 16'(code_exp[k] ^ p[0]), 16'(seen[0]));
        chk_port("terminal B", 16'(code_exp[k] ^ p[0]), 16'(seen[1]));
      end
    end
    // Zero clamp policies
    @(posedge clk) clreq <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1, `OFS_CLAMP_POLICY, 32'(cp[i]));
      step(cf[i], cr[i]);
      chk_port("speed command", 16'(cc[i]), 16'(cmd));
      chk_port("position lock", 16'(cl[i]), 16'(lock));
    end
    bus(1, `OFS_CLAMP_POLICY, 32'h4);
    bus(0, `OFS_CLAMP_POLICY, 0);
    chk_reg("policy", 32'h3, rdata);
    bus(1, `OFS_CLAMP_POLICY, 32'h0);
    bus(1, `OFS_CLAMP_THR, 32'h1E);
    step(30, 25);
    chk_port("speed command", 16'h0, 16'(cmd));
    bus(1, `OFS_CLAMP_THR, 32'h3E9);
    bus(0, `OFS_CLAMP_THR, 0);
    chk_reg("clamp threshold", 32'h1E, rdata);
    bus(1, `OFS_CLAMP_THR, 32'h3E8);
    bus(0, `OFS_CLAMP_THR, 0);
    chk_reg("clamp threshold", 32'h3E8, rdata);
    @(posedge clk) clreq <= 1'b0;
    // Torque source only follows a write made while not running
    @(posedge clk) run <= 1'b1;
    bus(1, `OFS_TORQUE_SRC, 32'h1);
    bus(0, `OFS_TORQUE_SRC, 0);
    chk_reg("torque source", 32'h0, rdata);
    step(0, 0);
    chk_port("torque ref", 16'(tint), 16'(tref));
    @(posedge clk) run <= 1'b0;
    bus(1, `OFS_TORQUE_SRC, 32'h1);
    step(0, 0);
    chk_port("torque ref", 16'(ain), 16'(tref));
    // Interrupt raise, clear and mask
    bus(1, `OFS_IRQ_MASK, 32'h1);
    step(0, 0);
    bus(1, `OFS_IRQ_STATUS, 32'h1F);
    chk_port("irq", 16'h0, 16'(irq));
    step(50, 50);
    chk_port("irq", 16'h1, 16'(irq));
    bus(0, `OFS_LIVE_STATUS, 0);
    chk_reg("live status", 32'h5, rdata);
    bus(1, `OFS_IRQ_STATUS, 32'h1);
    chk_port("irq", 16'h0, 16'(irq));
    bus(1, `OFS_IRQ_MASK, 32'h0);
    step(0, 0);
    step(50, 50);
    chk_port("irq", 16'h0, 16'(irq));
    bus(0, `OFS_IRQ_STATUS, 0);
    chk_reg("irq status", 32'h1, 32'(rdata[0]));
    results();
  end
endmodule

`default_nettype wire
